// ==== hw/uabd_pkg.sv ====
// Package for the auto-baud detect block: register map, fields, prescale counts, carriers
package uabd_pkg;
    localparam logic [7:0]  ADDR_CONTROL   = 8'h00;
    localparam logic [7:0]  ADDR_DIV_LOW   = 8'h04;
    localparam logic [7:0]  ADDR_DIV_HIGH  = 8'h08;
    localparam logic [7:0]  ADDR_RX_BUFFER = 8'h0C;
    localparam logic [7:0]  ADDR_STATUS    = 8'h10;
    localparam int          BIT_ABD_EN     = 0;
    localparam int          BIT_WUE_EN     = 1;
    localparam int          BIT_WIDE_SEL   = 2;
    localparam int          BIT_HS_SEL     = 3;
    localparam int          BIT_RX_FLAG    = 0;
    localparam int          BIT_BUSY       = 1;
    localparam int          BIT_RX_IDLE    = 2;
    localparam logic [3:0]  CONTROL_RESET  = 4'h0;
    localparam logic [15:0] DIV_RESET      = 16'h0000;
    localparam logic [15:0] DIV_START      = 16'h0001;
    localparam logic [8:0]  PRE_SLOW       = 9'h1FF;
    localparam logic [8:0]  PRE_MID        = 9'h07F;
    localparam logic [8:0]  PRE_FAST       = 9'h01F;
    localparam logic [2:0]  EDGES_TO_END   = 3'h4;

    typedef enum logic [2:0] {
        UABD_IDLE  = 3'b000,
        UABD_BREAK = 3'b001,
        UABD_BRKHI = 3'b010,
        UABD_START = 3'b011,
        UABD_FIRST = 3'b100,
        UABD_COUNT = 3'b101
    } uabd_state_t;

    typedef struct packed {
        logic [7:0]  adr;
        logic        we;
        logic [3:0]  sel;
        logic [31:0] dat;
        logic        cyc;
        logic        stb;
    } uabd_wb_req_t;
endpackage : uabd_pkg

// ==== hw/uabd_prescale.sv ====
// Prescaler producing one tick per auto-baud counter clock period
`timescale 1ns/10ps
module uabd_prescale (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       run_i,
    input  wire logic       wide_i,
    input  wire logic       hs_i,
    output logic            tick_o
);
    import uabd_pkg::*;

    typedef struct packed {
        logic [8:0] cnt;
        logic       tick;
    } uabd_pre_st_t;

    uabd_pre_st_t st_reg;
    uabd_pre_st_t st_next;
    logic [8:0]   limit;

    always_comb begin
        // Counter clock is the base clock divided by 512, 128 or 32 by the select bits
        case ({wide_i, hs_i})
            2'b00:   limit = PRE_SLOW;
            2'b11:   limit = PRE_FAST;
            default: limit = PRE_MID;
        endcase
    end

    always_comb begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        if (!run_i) begin
            st_next.cnt = 9'h000;
        end else if (st_reg.cnt >= limit) begin
            st_next.cnt  = 9'h000;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 9'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick_o = st_reg.tick;
endmodule : uabd_prescale

// ==== hw/uabd_top.sv ====
// Auto-baud detect block with classic Wishbone register slave
// Functional notes
// - Setting autobaud_enable starts a measurement on the receive line.
// - Receive state machine is held idle while measuring.
// - Counting starts at the first rising edge after the start bit.
// - Measurement ends at the fifth rising edge, end of bit eight.
// - At end, count stays in divisor pair, enable clears, receive_flag sets.
// - Reading receive_buffer clears receive_flag; software discards the byte.
// - Both divisor bytes form one 16-bit counter during measurement.
// - Counter advances at 1/512, 1/128 or 1/32 of the base clock rate.
// - Counter clock is Fosc/512, Fosc/128 or Fosc/32 by select bits.
// - With wake_on_break_enable, measure the character after the break.
// - Counter starts from one, not zero.
// - Result is average bit time in full-speed generator counts.
// - Sync character gives five rising edges, last is stop bit edge.
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
module uabd_top (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire uabd_pkg::uabd_wb_req_t wb_req_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic                  rx_i,
    input  wire logic [7:0]            rx_data_i,
    input  wire logic                  rx_data_valid_i,
    output logic                       rx_hold_idle_o,
    output logic [15:0]                rate_divisor_o,
    output logic                       receive_flag_o
);
    import uabd_pkg::*;

    typedef struct packed {
        uabd_state_t fsm;
        logic        abd_en;
        logic        wue_en;
        logic        wide_sel;
        logic        hs_sel;
        logic [15:0] divisor;
        logic [2:0]  edges;
        logic        rx_prev;
        logic        rx_flag;
        logic [7:0]  rx_buf;
        logic        ack;
        logic [31:0] rdata;
    } uabd_st_t;

    uabd_st_t st_reg;
    uabd_st_t st_next;
    logic     tick;
    logic     rise;
    logic     fall;
    logic     access;
    logic     wr_ctl;
    logic     counting;

    assign rise     = rx_i && !st_reg.rx_prev;
    assign fall     = !rx_i && st_reg.rx_prev;
    assign access   = wb_req_i.cyc && wb_req_i.stb && !st_reg.ack;
    assign wr_ctl   = access && wb_req_i.we && wb_req_i.sel[0] && (wb_req_i.adr == ADDR_CONTROL);
    assign counting = (st_reg.fsm == UABD_COUNT);

    uabd_prescale u_prescale (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .run_i  (counting),
        .wide_i (st_reg.wide_sel),
        .hs_i   (st_reg.hs_sel),
        .tick_o (tick)
    );

    always_comb begin
        st_next         = st_reg;
        st_next.rx_prev = rx_i;
        st_next.ack     = access;

        if (access && !wb_req_i.we) begin
            case (wb_req_i.adr)
                ADDR_CONTROL: begin
                    st_next.rdata = {28'h0000000, st_reg.hs_sel, st_reg.wide_sel, st_reg.wue_en, st_reg.abd_en};
                end
                ADDR_DIV_LOW:   st_next.rdata = {24'h000000, st_reg.divisor[7:0]};
                ADDR_DIV_HIGH:  st_next.rdata = {24'h000000, st_reg.divisor[15:8]};
                ADDR_RX_BUFFER: begin
                    st_next.rdata   = {24'h000000, st_reg.rx_buf};
                    st_next.rx_flag = 1'b0;
                end
                ADDR_STATUS: begin
                    st_next.rdata = {29'h00000000, (st_reg.fsm == UABD_IDLE), st_reg.abd_en, st_reg.rx_flag};
                end
                default:        st_next.rdata = 32'h00000000;
            endcase
        end

        // Normal receive path loads the buffer only when not measuring; a new byte beats a same-cycle buffer read
        if (rx_data_valid_i && st_reg.fsm == UABD_IDLE && !st_reg.abd_en) begin
            st_next.rx_buf  = rx_data_i;
            st_next.rx_flag = 1'b1;
        end

        if (access && wb_req_i.we) begin
            if (wr_ctl) begin
                st_next.abd_en   = wb_req_i.dat[BIT_ABD_EN];
                st_next.wue_en   = wb_req_i.dat[BIT_WUE_EN];
                st_next.wide_sel = wb_req_i.dat[BIT_WIDE_SEL];
                st_next.hs_sel   = wb_req_i.dat[BIT_HS_SEL];
            end
            if (wb_req_i.sel[0] && wb_req_i.adr == ADDR_DIV_LOW && st_reg.fsm == UABD_IDLE) begin
                st_next.divisor[7:0] = wb_req_i.dat[7:0];
            end
            if (wb_req_i.sel[0] && wb_req_i.adr == ADDR_DIV_HIGH && st_reg.fsm == UABD_IDLE) begin
                st_next.divisor[15:8] = wb_req_i.dat[7:0];
            end
        end

        case (st_reg.fsm)
            UABD_IDLE: begin
                if (st_reg.abd_en) begin
                    if (st_reg.wue_en) begin
                        st_next.fsm = UABD_BREAK;
                    end else begin
                        st_next.fsm = UABD_START;
                    end
                end
            end
            UABD_BREAK: begin
                if (fall) begin
                    st_next.fsm = UABD_BRKHI;
                end
            end
            UABD_BRKHI: begin
                // Break ends on the line's return high; next low is the sync start bit
                if (rise) begin
                    st_next.fsm = UABD_START;
                end
            end
            UABD_START: begin
                if (fall) begin
                    st_next.fsm = UABD_FIRST;
                end
            end
            UABD_FIRST: begin
                if (rise) begin
                    st_next.fsm     = UABD_COUNT;
                    st_next.divisor = DIV_START;
                    st_next.edges   = 3'h0;
                end
            end
            UABD_COUNT: begin
                if (tick) begin
                    st_next.divisor = st_reg.divisor + 16'h0001;
                end
                if (rise) begin
                    st_next.edges = st_reg.edges + 3'h1;
                    if (st_reg.edges == EDGES_TO_END - 3'h1) begin
                        st_next.fsm     = UABD_IDLE;
                        st_next.abd_en  = 1'b0;
                        st_next.rx_flag = 1'b1;
                    end
                end
            end
            default: st_next.fsm = UABD_IDLE;
        endcase

        // Software cancelling the enable aborts any measurement in progress
        if (wr_ctl && !wb_req_i.dat[BIT_ABD_EN]) begin
            st_next.fsm = UABD_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg          <= '0;
            st_reg.fsm      <= UABD_IDLE;
            st_reg.divisor  <= DIV_RESET;
            st_reg.rx_prev  <= 1'b1;
            {st_reg.hs_sel, st_reg.wide_sel, st_reg.wue_en, st_reg.abd_en} <= CONTROL_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_dat_o       = st_reg.rdata;
    assign wb_ack_o       = st_reg.ack;
    assign rx_hold_idle_o = st_reg.abd_en || (st_reg.fsm != UABD_IDLE);
    assign rate_divisor_o = st_reg.divisor;
    assign receive_flag_o = st_reg.rx_flag;
endmodule : uabd_top

// ==== testbench/uabd_checker.sv ====
// Assertion checker for the auto-baud detect block
`timescale 1ns/10ps
module uabd_checker import uabd_pkg::*; (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire uabd_pkg::uabd_wb_req_t wb_req_i,
    input  wire logic [31:0]            wb_dat_o,
    input  wire logic                   wb_ack_o,
    input  wire logic                   rx_i,
    input  wire logic [7:0]             rx_data_i,
    input  wire logic                   rx_data_valid_i,
    input  wire logic                   rx_hold_idle_o,
    input  wire logic [15:0]            rate_divisor_o,
    input  wire logic                   receive_flag_o
);
    localparam int MIN_GAP = 28;
    logic [15:0] prev_div_reg;
    logic [9:0]  gap_reg;
    // Cycles since the divisor last changed
    always_ff @(posedge clk_i) begin
        prev_div_reg <= rate_divisor_o;
        gap_reg      <= (rst_i || rate_divisor_o != prev_div_reg) ? 10'h000 : gap_reg + 10'h001;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take; wb_req_i.cyc && wb_req_i.stb && !wb_ack_o; endsequence
    sequence s_arm; wb_ack_o && wb_req_i.cyc && wb_req_i.we && wb_req_i.adr == ADDR_CONTROL && wb_req_i.dat[0]; endsequence
    sequence s_buf_rd;
        wb_ack_o && wb_req_i.cyc && !wb_req_i.we && wb_req_i.adr == ADDR_RX_BUFFER && !rx_hold_idle_o && !rx_data_valid_i;
    endsequence
    sequence s_step; rx_hold_idle_o && rate_divisor_o != prev_div_reg && rate_divisor_o != DIV_START; endsequence
    sequence s_end; $rose(receive_flag_o) && $past(rx_hold_idle_o); endsequence
    property p_ack_answer; s_take |=> wb_ack_o; endproperty
    property p_ack_single; wb_ack_o |=> !wb_ack_o; endproperty
    property p_hold_on_arm; s_arm |=> rx_hold_idle_o; endproperty
    property p_buf_clear; s_buf_rd |=> !receive_flag_o; endproperty
    property p_end_on_rise; s_end |-> rx_i; endproperty
    property p_end_release; s_end |-> ##[0:1] !rx_hold_idle_o; endproperty
    property p_count_step; s_step |-> rate_divisor_o == prev_div_reg + 16'h0001; endproperty
    property p_step_gap; s_step |-> gap_reg >= MIN_GAP; endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("no ack after request");
    a_ack_single: assert property (p_ack_single) else $error("ack longer than one cycle");
    a_hold_on_arm: assert property (p_hold_on_arm) else $error("receiver not held after arming");
    a_buf_clear: assert property (p_buf_clear) else $error("flag kept after buffer read");
    a_end_on_rise: assert property (p_end_on_rise) else $error("end not on a high line");
    a_end_release: assert property (p_end_release) else $error("enable not cleared at end");
    a_count_step: assert property (p_count_step) else $error("divisor step not plus one");
    a_step_gap: assert property (p_step_gap) else $error("divisor stepped too fast");
endmodule : uabd_checker
bind uabd_top uabd_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rx_i(rx_i), .rx_data_i(rx_data_i), .rx_data_valid_i(rx_data_valid_i),
    .rx_hold_idle_o(rx_hold_idle_o), .rate_divisor_o(rate_divisor_o), .receive_flag_o(receive_flag_o));

// ==== testbench/uabd_sync_tx.sv ====
// Remote transmitter model: optional break, then the sync character
`timescale 1ns/10ps
module uabd_sync_tx (
    input  wire logic        clk_i,
    input  wire logic        go_i,
    input  wire logic        brk_i,
    input  wire logic [15:0] bit_cyc_i,
    output logic             rx_o
);
    localparam logic [9:0] FRAME = {1'b1, 8'h55, 1'b0};
    initial rx_o = 1'b1;
    always @(posedge clk_i) begin
        if (go_i) begin
            if (brk_i) begin
                rx_o <= 1'b0;
                repeat (13 * bit_cyc_i) @(posedge clk_i);
                rx_o <= 1'b1;
                repeat (bit_cyc_i) @(posedge clk_i);
            end
            for (int i = 0; i < 10; i++) begin
                rx_o <= FRAME[i];
                repeat (bit_cyc_i) @(posedge clk_i);
            end
        end
    end
endmodule : uabd_sync_tx

// ==== testbench/tb_uart_autobaud_detect.sv ====
// Self-checking testbench for the auto-baud detect block
`timescale 1ns/10ps
module tb_uart_autobaud_detect;
    import uabd_pkg::*;
    logic         clk_i = 1'b0, rst_i = 1'b1, rx_i, rx_dv = 1'b0, go = 1'b0, brk = 1'b0;
    uabd_wb_req_t req = '0;
    logic [31:0]  wb_dat_o, expq[$];
    logic         wb_ack_o, rx_hold_idle_o, receive_flag_o;
    logic [15:0]  rate_divisor_o, bit_cyc = 16'h00CA;
    logic [7:0]   rx_data = 8'h00;
    int           mismatches = 0, n_checks = 0, seed = 64;
    always #12.5 clk_i = ~clk_i;
    uabd_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .rx_i(rx_i), .rx_data_i(rx_data), .rx_data_valid_i(rx_dv), .rx_hold_idle_o(rx_hold_idle_o),
        .rate_divisor_o(rate_divisor_o), .receive_flag_o(receive_flag_o));
    uabd_sync_tx i_tx (.clk_i(clk_i), .go_i(go), .brk_i(brk), .bit_cyc_i(bit_cyc), .rx_o(rx_i));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        req <= '{adr: a, we: we, sel: 4'hF, dat: d, cyc: 1'b1, stb: 1'b1};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            if (n > 20) begin
                mismatches++;
                report_and_stop();
            end
        end while (wb_ack_o !== 1'b1);
        req <= '0;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        wb(a, 1'b0, 32'h0);
    endtask : rd
    // Read results are compared by the watcher as the ack appears
    always @(posedge clk_i) begin
        if (wb_ack_o && req.cyc && !req.we && expq.size() > 0) chk(wb_dat_o, expq.pop_front());
    end
    task automatic measure(input logic [3:0] ctl, input int per);
        int n;
        wb(ADDR_CONTROL, 1'b1, {28'h0, ctl});
        bit_cyc <= 16'(per * 101 / 16);
        brk <= ctl[BIT_WUE_EN];
        go <= 1'b1;
        rx_data <= 8'($random(seed));
        rx_dv <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        rx_dv <= 1'b0;
        @(posedge clk_i);
        chk(rx_hold_idle_o, 1'b1);
        chk(receive_flag_o, 1'b0);
        for (n = 0; n < 50000 && receive_flag_o !== 1'b1; n++) @(posedge clk_i);
        if (n == 50000) begin
            mismatches++;
            report_and_stop();
        end
        chk(32'(rate_divisor_o), 32'h33);
        chk(32'(rate_divisor_o - 16'h0001), 32'h32);
        chk(rx_hold_idle_o, 1'b0);
        rd(ADDR_DIV_LOW, 32'h33);
        rd(ADDR_DIV_HIGH, 32'h0);
        rd(ADDR_CONTROL, {28'h0, ctl & 4'hE});
        wb(ADDR_RX_BUFFER, 1'b0, 32'h0);
        @(posedge clk_i);
        chk(receive_flag_o, 1'b0);
        repeat (per * 7) @(posedge clk_i);
        $display("measurement done, control %h", ctl);
    endtask : measure
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ADDR_CONTROL, 32'h0);
        rd(ADDR_DIV_HIGH, 32'h0);
        rd(8'h20, 32'h0);
        wb(ADDR_DIV_LOW, 1'b1, 32'h5A);
        wb(ADDR_DIV_HIGH, 1'b1, 32'hA5);
        rd(ADDR_DIV_LOW, 32'h5A);
        rd(ADDR_DIV_HIGH, 32'hA5);
        rd(ADDR_STATUS, 32'h4);
        wb(ADDR_CONTROL, 1'b1, 32'h1);
        wb(ADDR_CONTROL, 1'b1, 32'h0);
        @(posedge clk_i);
        chk(rx_hold_idle_o, 1'b0);
        $display("reset values done");
        for (int m = 0; m < 4; m++) measure({m[1:0], 2'b01}, m == 0 ? 512 : (m == 3 ? 32 : 128));
        measure(4'hF, 32);
        repeat (3) begin
            @(posedge clk_i);
            rx_data <= 8'($random(seed));
            rx_dv <= 1'b1;
            @(posedge clk_i);
            rx_dv <= 1'b0;
            @(posedge clk_i);
            chk(receive_flag_o, 1'b1);
            rd(ADDR_RX_BUFFER, {24'h0, rx_data});
            @(posedge clk_i);
            chk(receive_flag_o, 1'b0);
        end
        $display("buffer reads done");
        report_and_stop();
    end
endmodule : tb_uart_autobaud_detect
